// file: shared/ocr_pkg.sv
package ocr_pkg;

  // ****************************************
  // Serial word layout
  // ****************************************
  localparam int WORD_W        = 16;
  localparam int BANK_BIT      = 13;
  localparam int ADDR_HI       = 12;
  localparam int ADDR_LO       = 10;
  localparam int DATA_W        = 9;
  localparam logic [2:0] ADDR_OCR   = 3'h4;
  localparam logic [2:0] ADDR_RETRY = 3'h5;

  // ****************************************
  // Field positions, overcurrent_profile_config
  // ****************************************
  localparam int F_HIGH_RANGE  = 8;
  localparam int F_EXT_DIV     = 7;
  localparam int F_CLK_INT     = 6;
  localparam int F_SENSE_RATIO = 5;
  localparam int F_WIN1_TIME   = 4;
  localparam int F_WIN2_TIME   = 3;
  localparam int F_UPPER_TH    = 2;
  localparam int F_MIDDLE_TH   = 1;
  localparam int F_LOW_TH      = 0;

  // ****************************************
  // Field positions, auto_retry_config
  // ****************************************
  localparam int F_OFFSET_POL  = 8;
  localparam int F_PERIOD_MSB  = 3;
  localparam int F_PERIOD_LSB  = 2;
  localparam int F_UNLIMITED   = 1;
  localparam int F_RETRY       = 0;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [8:0] OCR_RESET   = 9'h000;
  localparam logic [8:0] RETRY_RESET = 9'h000;
  localparam logic [9:0] DIV_LOW     = 10'h100;
  localparam logic [9:0] DIV_HIGH    = 10'h200;
  localparam int         RETRY_CNT_W = 5;
  localparam logic [4:0] RETRY_LIMIT = 5'h10;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0]
  {
    OCL_HIGHEST = 2'h0,
    OCL_MEDIUM  = 2'h1,
    OCL_LOWEST  = 2'h3
  } ocr_low_level_t;

  typedef enum logic [2:0]
  {
    WIN_IDLE = 3'h0,
    WIN_HIGH = 3'h1,
    WIN_MID  = 3'h3,
    WIN_LOW  = 3'h2
  } ocr_win_state_t;

  typedef struct packed
  {
    logic       valid;
    logic [15:0] word;
  } ocr_serial_t;

  typedef struct packed
  {
    logic           upper_sel;
    logic           middle_en;
    logic           middle_sel;
    ocr_low_level_t low_level;
    logic           ratio_low;
    logic           win1_sel;
    logic           win2_sel;
    logic [1:0]     motor_time_sel;
    logic [9:0]     ext_divider;
    logic           clock_internal;
    logic           offset_add;
    logic [1:0]     retry_period;
    logic           retry_enable;
    logic           retry_unlimited;
  } ocr_chan_cfg_t;

endpackage

// file: rtl/ocr_config.sv
`timescale 1ns/1ps
// Contract
// R1 - Lamp profile applies high, middle, low thresholds, each in its own slot.
// R2 - Motor profile applies only high and low thresholds, no middle stage.
// R3 - Low sense ratio scales all thresholds down by three.
// R4 - High-range bit 0 forces highest low level; at 1 bit D0 picks medium/lowest.
// R5 - Current sensing unavailable while any overcurrent window is active.
// R6 - External clock divided by 512 when divider bit is 1, else 256.
// R7 - Clock source bit 1 selects internal clock; 0 selects external.
// R8 - Sense ratio bit 1 low-current ratio, 0 high-current ratio (default).
// R9 - Lamp: two windows; D4 picks first duration, D3 picks second.
// R10 - Motor: one window; bits 4:3 choose among two middle and two high times.
// R11 - Upper threshold bit 0 larger (default), 1 smaller.
// R12 - Middle threshold bit 0 larger, 1 smaller; ignored in motor profile.
// R13 - Offset polarity 1 adds offset to sense output, 0 subtracts it.
// R14 - Two period bits select one of four retry periods, 00 default.
// R15 - Unlimited bit 1 allows endless retries if retry is enabled.
// R16 - Unlimited bit 0 stops retries after 16.
// R17 - Delatch or fault removal never clears the retry count.
// R18 - Lamp profile: retry bit 1 disables, 0 enables auto-retry.
// R19 - Motor profile: retry bit 1 enables, 0 disables auto-retry.
// R20 - Serial word bit 13 picks the channel bank written.
// R21 - Retry-full flag set when counter full, cleared when counter reset.
// R22 - Retry counter increments per attempt and saturates at the limit.
// R23 - All configuration fields reset to zero in both banks.

module ocr_config
(
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire ocr_pkg::ocr_serial_t serial_in,
  input  wire logic [1:0]           load_type_input,
  input  wire logic [1:0]           retry_attempt,
  input  wire logic [1:0]           retry_counter_reset,
  input  wire logic [1:0]           fault_delatch,
  input  wire logic [1:0]           window_active,
  output      ocr_pkg::ocr_chan_cfg_t cfg_ch0,
  output      ocr_pkg::ocr_chan_cfg_t cfg_ch1,
  output      logic [1:0]           retry_allowed,
  output      logic [1:0]           retry_full,
  output      logic [1:0]           sense_available
);
  import ocr_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] load_meta_reg;
  logic [1:0] load_sync_reg;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      load_meta_reg <= 2'h0;
      load_sync_reg <= 2'h0;
    end
    else
    begin
      load_meta_reg <= load_type_input;
      load_sync_reg <= load_meta_reg;
    end
  end

  // ****************************************
  // Write decode
  // ****************************************
  wire [2:0] wr_addr  = serial_in.word[ADDR_HI:ADDR_LO];
  wire       wr_bank  = serial_in.word[BANK_BIT];                        // R20
  wire [8:0] wr_data  = serial_in.word[DATA_W-1:0];
  wire       wr_ocr   = serial_in.valid && (wr_addr == ADDR_OCR);
  wire       wr_retry = serial_in.valid && (wr_addr == ADDR_RETRY);

  logic [8:0] ocr_reg   [2];
  logic [8:0] retry_reg [2];
  logic [4:0] count_reg [2];
  ocr_chan_cfg_t cfg_next [2];
  ocr_chan_cfg_t cfg_reg  [2];
  logic [1:0] allowed_next;
  logic [1:0] full_next;
  logic [1:0] allowed_reg;
  logic [1:0] full_reg;
  logic [1:0] sense_reg;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      wire sel   = (wr_bank == 1'(ch));
      wire motor = load_sync_reg[ch];
      wire [8:0] o = ocr_reg[ch];
      wire [8:0] r = retry_reg[ch];
      wire en    = motor ? r[F_RETRY] : !r[F_RETRY];                     // R18 R19
      wire full  = (count_reg[ch] == RETRY_LIMIT);
      wire may   = en && (r[F_UNLIMITED] || !full);                      // R15 R16

      always_ff @(posedge sys_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          ocr_reg[ch]   <= OCR_RESET;                                    // R23
          retry_reg[ch] <= RETRY_RESET;                                  // R23
        end
        else
        begin
          if (wr_ocr && sel)
            ocr_reg[ch] <= wr_data;
          if (wr_retry && sel)
            retry_reg[ch] <= wr_data;
        end
      end

      // Delatch and fault removal deliberately have no path here
      always_ff @(posedge sys_clk or negedge nrst)
      begin
        if (!nrst)
          count_reg[ch] <= 5'h00;
        else if (retry_counter_reset[ch])
          count_reg[ch] <= 5'h00;                                        // R17 R21
        else if (retry_attempt[ch] && !full)
          count_reg[ch] <= count_reg[ch] + 5'h01;                        // R22
      end

      always_comb
      begin
        cfg_next[ch] = '0;
        cfg_next[ch].upper_sel      = o[F_UPPER_TH];                     // R11
        cfg_next[ch].middle_en      = !motor;                            // R1 R2
        cfg_next[ch].middle_sel     = motor ? 1'b0 : o[F_MIDDLE_TH];     // R12
        if (!o[F_HIGH_RANGE])
          cfg_next[ch].low_level    = OCL_HIGHEST;                       // R4
        else if (o[F_LOW_TH])
          cfg_next[ch].low_level    = OCL_LOWEST;                        // R4
        else
          cfg_next[ch].low_level    = OCL_MEDIUM;                        // R4
        cfg_next[ch].ratio_low      = o[F_SENSE_RATIO];                  // R3 R8
        cfg_next[ch].win1_sel       = motor ? 1'b0 : o[F_WIN1_TIME];     // R9
        cfg_next[ch].win2_sel       = motor ? 1'b0 : o[F_WIN2_TIME];     // R9
        cfg_next[ch].motor_time_sel = motor ? o[F_WIN1_TIME:F_WIN2_TIME]
                                            : 2'h0;                      // R10
        cfg_next[ch].ext_divider    = o[F_EXT_DIV] ? DIV_HIGH : DIV_LOW; // R6
        cfg_next[ch].clock_internal = o[F_CLK_INT];                      // R7
        cfg_next[ch].offset_add     = r[F_OFFSET_POL];                   // R13
        cfg_next[ch].retry_period   = r[F_PERIOD_MSB:F_PERIOD_LSB];      // R14
        cfg_next[ch].retry_enable   = en;
        cfg_next[ch].retry_unlimited = r[F_UNLIMITED];
        allowed_next[ch] = may;
        full_next[ch]    = full;                                         // R21
      end

      always_ff @(posedge sys_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          cfg_reg[ch]     <= '0;
          allowed_reg[ch] <= 1'b0;
          full_reg[ch]    <= 1'b0;
          sense_reg[ch]   <= 1'b0;
        end
        else
        begin
          cfg_reg[ch]     <= cfg_next[ch];
          allowed_reg[ch] <= allowed_next[ch];
          full_reg[ch]    <= full_next[ch];
          sense_reg[ch]   <= !window_active[ch];                         // R5
        end
      end
    end
  endgenerate

  assign cfg_ch0         = cfg_reg[0];
  assign cfg_ch1         = cfg_reg[1];
  assign retry_allowed   = allowed_reg;
  assign retry_full      = full_reg;
  assign sense_available = sense_reg;

endmodule

// file: tb/ocr_host_model.sv
`timescale 1ns/1ps
module ocr_host_model
(
  input  wire logic         sys_clk,
  output ocr_pkg::ocr_serial_t serial_in
);
  import ocr_pkg::*;
  initial serial_in = '0;
  // One word per call; the word is scrambled once released
  task automatic send(input logic b, input logic [2:0] a, input logic [8:0] d);
    @(posedge sys_clk);
    serial_in <= '{1'b1, {2'h0, b, a, 1'b0, d}};
    @(posedge sys_clk);
    serial_in <= '{1'b0, ~{2'h0, b, a, 1'b0, d}};
  endtask
endmodule

// file: tb/ocr_config_properties.sv
`timescale 1ns/1ps
module ocr_config_properties
(
  input wire logic                   sys_clk,
  input wire logic                   nrst,
  input wire ocr_pkg::ocr_serial_t   serial_in,
  input wire logic [1:0]             load_type_input,
  input wire logic [1:0]             retry_counter_reset,
  input wire logic [1:0]             window_active,
  input wire ocr_pkg::ocr_chan_cfg_t cfg_ch0,
  input wire ocr_pkg::ocr_chan_cfg_t cfg_ch1,
  input wire logic [1:0]             retry_full,
  input wire logic [1:0]             sense_available
);
  import ocr_pkg::*;
  wire [15:0] w = serial_in.word;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_wr0; serial_in.valid && w[13:10] == 4'h4; endsequence
  sequence s_wr1; serial_in.valid && w[13:10] == 4'hC; endsequence
  a_divider_sel:
  assert property (s_wr0 |-> ##2 cfg_ch0.ext_divider == ($past(w[7], 2) ? DIV_HIGH : DIV_LOW))
    else $error("divider wrong");
  a_clock_source:
  assert property (s_wr0 |-> ##2 cfg_ch0.clock_internal == $past(w[6], 2)) else $error("clk src");
  a_ratio_upper:
  assert property (s_wr1 |-> ##2 {cfg_ch1.ratio_low, cfg_ch1.upper_sel} ==
    {$past(w[5], 2), $past(w[2], 2)}) else $error("ratio or upper wrong");
  a_low_level:
  assert property (s_wr0 |-> ##2 cfg_ch0.low_level == (!$past(w[8], 2) ? OCL_HIGHEST :
    $past(w[0], 2) ? OCL_LOWEST : OCL_MEDIUM)) else $error("low level wrong");
  a_middle_motor:
  assert property (load_type_input[1] [*6] |-> !cfg_ch1.middle_en && !cfg_ch1.middle_sel)
    else $error("middle in motor");
  a_sense_block:
  assert property (window_active[0] |=> !sense_available[0]) else $error("sense in window");
  a_full_clear:
  assert property (retry_counter_reset[0] |-> ##2 !retry_full[0]) else $error("full kept");
  a_full_holds:
  assert property (retry_full[0] && !retry_counter_reset[0] && !$past(retry_counter_reset[0])
    |=> retry_full[0]) else $error("full lost");
endmodule
bind ocr_config ocr_config_properties i_ocr_config_properties (.sys_clk, .nrst, .serial_in,
  .load_type_input, .retry_counter_reset, .window_active, .cfg_ch0, .cfg_ch1, .retry_full,
  .sense_available);

// file: tb/ocr_config_test.sv
`timescale 1ns/1ps
module ocr_config_test;
  import ocr_pkg::*;
  logic          sys_clk = 0;
  logic          nrst = 0;
  logic [1:0]    lt = 0;
  logic [1:0]    wa = 0;
  logic [5:0]    pul = 0;
  ocr_serial_t   ser;
  ocr_chan_cfg_t c0, c1;
  logic [1:0]    al, fu, sa;
  int            n_fail = 0;
  int            n_compared = 0;
  logic [8:0]    ot[4] = '{9'h0A5, 9'h10D, 9'h0D2, 9'h1FF};
  logic [8:0]    rt[4] = '{9'h000, 9'h104, 9'h108, 9'h1FF};
  ocr_host_model i_ocr_host_model (.sys_clk, .serial_in(ser));
  ocr_config i_ocr_config (.sys_clk, .nrst, .serial_in(ser), .load_type_input(lt),
    .retry_attempt(pul[1:0]), .retry_counter_reset(pul[3:2]), .fault_delatch(pul[5:4]),
    .window_active(wa), .cfg_ch0(c0), .cfg_ch1(c1), .retry_allowed(al), .retry_full(fu),
    .sense_available(sa));
  initial forever #2 sys_clk = ~sys_clk;
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  function automatic ocr_chan_cfg_t ex(logic [8:0] o, logic [8:0] r, logic m);
    ex = '{o[2], !m, o[1] & !m, !o[8] ? OCL_HIGHEST : o[0] ? OCL_LOWEST : OCL_MEDIUM,
      o[5], o[4] & !m, o[3] & !m, m ? o[4:3] : 2'h0, o[7] ? DIV_HIGH : DIV_LOW,
      o[6], r[8], r[3:2], r[0] ^ !m, r[1]};
  endfunction
  task automatic t_cfg(input logic b, input logic m, input logic [8:0] o, input logic [8:0] r);
    i_ocr_host_model.send(b, 3'h4, o);
    i_ocr_host_model.send(b, 3'h5, r);
    repeat (2) @(posedge sys_clk);
    #1 cmp("cfg", 32'(ex(o, r, m)), 32'(b ? c1 : c0));
  endtask
  task automatic pulse(input logic [5:0] v, input int n);
    repeat (n)
    begin
      @(posedge sys_clk) pul <= v;
      @(posedge sys_clk) pul <= '0;
    end
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_retry;
    t_cfg(0, 0, 9'h000, 9'h000);
    pulse(6'h01, 17);
    cmp("full", 2'b01, fu);
    cmp("allowed", 2'b00, al[0]);
    pulse(6'h10, 1);
    cmp("full kept", 2'b01, fu);
    t_cfg(0, 0, 9'h000, 9'h002);
    cmp("allowed", 2'b01, al[0]);
    pulse(6'h04, 1);
    cmp("full clear", 2'b00, fu);
  endtask
  task automatic t_window;
    @(posedge sys_clk) wa <= 2'b01;
    repeat (2) @(posedge sys_clk);
    #1 cmp("sense", 2'b10, sa);
    @(posedge sys_clk) wa <= 2'b00;
  endtask
  task automatic end_of_test;
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_fail++;
    end_of_test();
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1;
    @(posedge sys_clk);
    #1 cmp("reset", 32'(ex(0, 0, 0)), 32'(c1));
    for (int i = 0; i < 4; i++) t_cfg(0, 0, ot[i], rt[i]);
    @(posedge sys_clk) lt <= 2'b10;
    repeat (6) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) t_cfg(1, 1, ot[i], rt[i]);
    cmp("bank0", 32'(ex(ot[3], rt[3], 0)), 32'(c0));
    t_retry();
    t_window();
    end_of_test();
  end
endmodule
